/* File: logic/i2c_timing_map.svh */
`ifndef I2C_TIMING_MAP_SVH
`define I2C_TIMING_MAP_SVH

// Register byte offsets.
`define OFS_IRQ_CLEAR      8'h38
`define OFS_DATA_HOLD      8'h4C
`define OFS_START_HOLD     8'h50
`define OFS_START_SETUP    8'h58
`define OFS_PENDING        8'h3C
`define OFS_MODE_CTRL      8'h40

// Interrupt-clear bit positions.
`define BIT_TX_OVERRUN     3
`define BIT_SLV_READ_REQ   16
`define BIT_SLV_READ_EMPTY 17
`define BIT_SLV_WRITE_REQ  18
`define BIT_MST_DONE       19
`define BIT_SLV_DONE       20
`define BIT_ARB_LOST       24
`define BIT_BUS_FAULT      25
`define BIT_MST_DONE_NOSTP 28

// Writable bit masks; everything else is reserved and reads zero.
`define IRQ_MASK           32'h131F_0008
`define TIME_MASK_LO       32'h0000_01FF
`define TIME_MASK_DUAL     32'h01FF_01FF

// Field positions of the dual-speed timing registers.
`define FLD_STD_LSB        0
`define FLD_FST_LSB        16

// Reset values.
`define RST_DATA_HOLD      9'h014
`define RST_HOLD_STD       9'h0E2
`define RST_HOLD_FST       9'h03F
`define RST_SETUP_STD      9'h0E2
`define RST_SETUP_FST      9'h01D

`endif

/* File: logic/i2c_timing_pkg.sv */
package i2c_timing_pkg;

  // Pending event flags, one per clearable interrupt source.
  typedef struct packed {
    logic tx_overrun;
    logic slv_read_req;
    logic slv_read_empty;
    logic slv_write_req;
    logic mst_done;
    logic slv_done;
    logic arb_lost;
    logic bus_fault;
    logic mst_done_nostop;
  } irq_vec_t;

  // Counter activity state, Gray coded along idle-hold-setup.
  typedef enum logic [1:0] {
    CNT_IDLE  = 2'h0,
    CNT_HOLD  = 2'h1,
    CNT_SETUP = 2'h3
  } cnt_state_t;

  // Timing requests from the serial engine.
  typedef struct packed {
    logic scl_fall;
    logic start_asserted;
    logic rstart_req;
  } timing_req_t;

  // Timing results towards the serial engine.
  typedef struct packed {
    logic data_change;
    logic scl_drive_low;
    logic start_issue;
  } timing_ack_t;

endpackage : i2c_timing_pkg

/* File: logic/i2c_irq_timing.sv */
// Functional notes
// - Writing one to a defined clear bit clears its pending flag; zero does nothing.
// - Clear bit 3 clears pending transmit FIFO overrun.
// - Clear bit 16 clears pending read-from-slave request.
// - Clear bit 17 clears pending read-from-slave empty.
// - Clear bit 18 clears pending write-to-slave request.
// - Clear bit 19 clears pending master transaction done.
// - Clear bit 20 clears pending slave transaction done.
// - Clear bit 24 clears pending master arbitration lost.
// - Clear bit 25 clears pending bus error.
// - Clear bit 28 clears pending master done without stop.
// - Each SCL falling edge loads the data hold count; data changes when reached.
// - Standard start: load standard start hold; drive SCL low when reached.
// - Fast start: load fast start hold; drive SCL low when reached.
// - Standard repeated start waits standard start setup before issuing start.
// - Fast repeated start waits fast start setup before issuing start.
// - Master done without stop status reads one until acknowledged.
// - Arbitration lost status reads one after loss until software clears it.
`timescale 1ns/1ps
`include "i2c_timing_map.svh"

module i2c_irq_timing
  import i2c_timing_pkg::*;
(
  input  wire logic        ref_clk_i,     // Peripheral clock, 250 MHz.
  input  wire logic        sys_rst_i,     // Synchronous reset, active high.
  input  wire logic [7:0]  addr_i,        // Register byte address.
  input  wire logic [31:0] wdata_i,       // Write data.
  input  wire logic        wr_i,          // Write strobe.
  input  wire logic        rd_i,          // Read strobe.
  output logic      [31:0] rdata_o,       // Read data, valid the cycle after rd_i.
  input  wire irq_vec_t    event_i,       // One-cycle event pulses from the engine.
  output irq_vec_t         pending_o,     // Pending (unmasked) status flags.
  input  wire timing_req_t req_i,         // Timing requests from the engine.
  output timing_ack_t      ack_o,         // One-cycle timing completion pulses.
  output logic             fast_mode_o    // Selected speed mode, 1 for fast.
);

  // Whole module state in one record.
  typedef struct packed {
    irq_vec_t   pend;
    logic [8:0] hold_dat;
    logic [8:0] sthold_std;
    logic [8:0] sthold_fst;
    logic [8:0] stsetup_std;
    logic [8:0] stsetup_fst;
    logic       fast;
    cnt_state_t st_state;
    logic [8:0] st_cnt;
    logic       dat_busy;
    logic [8:0] dat_cnt;
    timing_ack_t ack;
    logic [31:0] rdata;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // Maps a 32-bit clear word onto the flag record, only defined bits count.
  function automatic irq_vec_t clear_bits(input logic [31:0] w);
    irq_vec_t v;
    v.tx_overrun      = w[`BIT_TX_OVERRUN];
    v.slv_read_req    = w[`BIT_SLV_READ_REQ];
    v.slv_read_empty  = w[`BIT_SLV_READ_EMPTY];
    v.slv_write_req   = w[`BIT_SLV_WRITE_REQ];
    v.mst_done        = w[`BIT_MST_DONE];
    v.slv_done        = w[`BIT_SLV_DONE];
    v.arb_lost        = w[`BIT_ARB_LOST];
    v.bus_fault       = w[`BIT_BUS_FAULT];
    v.mst_done_nostop = w[`BIT_MST_DONE_NOSTP];
    return v;
  endfunction : clear_bits

  // Places the flag record back at its documented bit positions.
  function automatic logic [31:0] flag_word(input irq_vec_t v);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`BIT_TX_OVERRUN]     = v.tx_overrun;
    w[`BIT_SLV_READ_REQ]   = v.slv_read_req;
    w[`BIT_SLV_READ_EMPTY] = v.slv_read_empty;
    w[`BIT_SLV_WRITE_REQ]  = v.slv_write_req;
    w[`BIT_MST_DONE]       = v.mst_done;
    w[`BIT_SLV_DONE]       = v.slv_done;
    w[`BIT_ARB_LOST]       = v.arb_lost;
    w[`BIT_BUS_FAULT]      = v.bus_fault;
    w[`BIT_MST_DONE_NOSTP] = v.mst_done_nostop;
    return w;
  endfunction : flag_word

  // Packs a standard and a fast field into one dual timing word.
  function automatic logic [31:0] dual_word(input logic [8:0] s, input logic [8:0] f);
    return {7'h00, f, 7'h00, s};
  endfunction : dual_word

  // Next-state logic: register access, flags and timing counters.
  always_comb
  begin
    irq_vec_t clr;
    logic     wr_clr;
    state_nxt = state_r;
    clr       = '0;
    wr_clr    = wr_i && (addr_i == `OFS_IRQ_CLEAR);
    state_nxt.ack = '0;

    // Clear bits are used only in the write cycle and never stored.
    if (wr_clr)
    begin
      clr = clear_bits(wdata_i);
    end

    // A new event in the clear cycle wins so it is never lost.
    state_nxt.pend = irq_vec_t'((state_r.pend & ~clr) | event_i);
    state_nxt.pend.tx_overrun      = event_i.tx_overrun      | (state_r.pend.tx_overrun      & ~clr.tx_overrun);
    state_nxt.pend.slv_read_req    = event_i.slv_read_req    | (state_r.pend.slv_read_req    & ~clr.slv_read_req);
    state_nxt.pend.slv_read_empty  = event_i.slv_read_empty  | (state_r.pend.slv_read_empty  & ~clr.slv_read_empty);
    state_nxt.pend.slv_write_req   = event_i.slv_write_req   | (state_r.pend.slv_write_req   & ~clr.slv_write_req);
    state_nxt.pend.mst_done        = event_i.mst_done        | (state_r.pend.mst_done        & ~clr.mst_done);
    state_nxt.pend.slv_done        = event_i.slv_done        | (state_r.pend.slv_done        & ~clr.slv_done);
    state_nxt.pend.arb_lost        = event_i.arb_lost        | (state_r.pend.arb_lost        & ~clr.arb_lost);
    state_nxt.pend.bus_fault       = event_i.bus_fault       | (state_r.pend.bus_fault       & ~clr.bus_fault);
    state_nxt.pend.mst_done_nostop = event_i.mst_done_nostop | (state_r.pend.mst_done_nostop & ~clr.mst_done_nostop);

    // Timing field writes; reserved bits are dropped on the way in.
    if (wr_i)
    begin
      case (addr_i)
        `OFS_DATA_HOLD:
        begin
          state_nxt.hold_dat = wdata_i[8:0];
        end
        `OFS_START_HOLD:
        begin
          state_nxt.sthold_std = wdata_i[`FLD_STD_LSB +: 9];
          state_nxt.sthold_fst = wdata_i[`FLD_FST_LSB +: 9];
        end
        `OFS_START_SETUP:
        begin
          state_nxt.stsetup_std = wdata_i[`FLD_STD_LSB +: 9];
          state_nxt.stsetup_fst = wdata_i[`FLD_FST_LSB +: 9];
        end
        `OFS_MODE_CTRL:
        begin
          state_nxt.fast = wdata_i[0];
        end
        default:
        begin
          state_nxt.fast = state_r.fast;
        end
      endcase
    end

    // Data hold counter, restarted by every SCL falling edge.
    if (req_i.scl_fall)
    begin
      state_nxt.dat_busy = 1'b1;
      state_nxt.dat_cnt  = 9'h000;
    end
    else if (state_r.dat_busy)
    begin
      if (state_r.dat_cnt >= state_r.hold_dat)
      begin
        state_nxt.dat_busy        = 1'b0;
        state_nxt.ack.data_change = 1'b1;
      end
      else
      begin
        state_nxt.dat_cnt = state_r.dat_cnt + 9'h001;
      end
    end

    // Start hold and repeated start setup share one counter.
    case (state_r.st_state)
      CNT_IDLE:
      begin
        state_nxt.st_cnt = 9'h000;
        if (req_i.start_asserted)
        begin
          state_nxt.st_state = CNT_HOLD;
        end
        else if (req_i.rstart_req)
        begin
          state_nxt.st_state = CNT_SETUP;
        end
      end
      CNT_HOLD:
      begin
        // Mode is sampled live, so a mode change mid-count takes effect at once.
        if (state_r.st_cnt >= (state_r.fast ? state_r.sthold_fst : state_r.sthold_std))
        begin
          state_nxt.st_state          = CNT_IDLE;
          state_nxt.ack.scl_drive_low = 1'b1;
        end
        else
        begin
          state_nxt.st_cnt = state_r.st_cnt + 9'h001;
        end
      end
      CNT_SETUP:
      begin
        if (state_r.st_cnt >= (state_r.fast ? state_r.stsetup_fst : state_r.stsetup_std))
        begin
          state_nxt.st_state        = CNT_IDLE;
          state_nxt.ack.start_issue = 1'b1;
        end
        else
        begin
          state_nxt.st_cnt = state_r.st_cnt + 9'h001;
        end
      end
      default:
      begin
        state_nxt.st_state = CNT_IDLE;
      end
    endcase

    // Read data register; the clear register reads zero since nothing is held.
    state_nxt.rdata = 32'h0000_0000;
    if (rd_i)
    begin
      case (addr_i)
        `OFS_IRQ_CLEAR:   state_nxt.rdata = 32'h0000_0000;
        `OFS_DATA_HOLD:   state_nxt.rdata = {23'h000000, state_r.hold_dat};
        `OFS_START_HOLD:  state_nxt.rdata = dual_word(state_r.sthold_std, state_r.sthold_fst);
        `OFS_START_SETUP: state_nxt.rdata = dual_word(state_r.stsetup_std, state_r.stsetup_fst);
        `OFS_PENDING:     state_nxt.rdata = flag_word(state_r.pend);
        `OFS_MODE_CTRL:   state_nxt.rdata = {31'h00000000, state_r.fast};
        default:          state_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register with synchronous reset to documented values.
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r             <= '0;
      state_r.hold_dat    <= `RST_DATA_HOLD;
      state_r.sthold_std  <= `RST_HOLD_STD;
      state_r.sthold_fst  <= `RST_HOLD_FST;
      state_r.stsetup_std <= `RST_SETUP_STD;
      state_r.stsetup_fst <= `RST_SETUP_FST;
      state_r.st_state    <= CNT_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Outputs straight from the state record.
  assign rdata_o     = state_r.rdata;
  assign pending_o   = state_r.pend;
  assign ack_o       = state_r.ack;
  assign fast_mode_o = state_r.fast;

endmodule : i2c_irq_timing

/* File: verification/engine_model.sv */
`timescale 1ns/1ps
module engine_model
  import i2c_timing_pkg::*;
(
  input  wire logic        ref_clk_i, // Clock.
  input  wire logic        sys_rst_i, // Reset.
  input  wire irq_vec_t    ev_cmd_i,  // Events asked for.
  input  wire timing_req_t rq_cmd_i,  // Requests asked for.
  output irq_vec_t         event_o,   // Event pulses.
  output timing_req_t      req_o      // Timing requests.
);
  // Pulses leave just after an edge, so the block never sees a half-cycle request.
  always_ff @(posedge ref_clk_i)
  begin
    event_o <= sys_rst_i ? '0 : ev_cmd_i;
    req_o   <= sys_rst_i ? '0 : rq_cmd_i;
  end
endmodule : engine_model

/* File: verification/i2c_irq_timing_sva.sv */
`timescale 1ns/1ps
`include "i2c_timing_map.svh"
module i2c_irq_timing_sva
  import i2c_timing_pkg::*;
(
  input wire logic        ref_clk_i,  // Clock.
  input wire logic        sys_rst_i,  // Reset.
  input wire logic [7:0]  addr_i,     // Address.
  input wire logic [31:0] wdata_i,    // Write data.
  input wire logic        wr_i,       // Write strobe.
  input wire logic        rd_i,       // Read strobe.
  input wire logic [31:0] rdata_o,    // Read data.
  input wire irq_vec_t    event_i,    // Events.
  input wire irq_vec_t    pending_o,  // Pending flags.
  input wire timing_req_t req_i,      // Requests.
  input wire timing_ack_t ack_o,      // Acks.
  input wire logic        fast_mode_o // Mode.
);
  logic [8:0] hold_r; // Shadow of the data hold field.
  logic [9:0] dcnt_r; // Cycles since the last SCL fall.
  logic       darm_r; // A data hold count runs.
  irq_vec_t   clr;    // Clear bits of this cycle.
  // Clear bits in pending-flag order.
  assign clr = (wr_i && addr_i == `OFS_IRQ_CLEAR) ? {wdata_i[3], wdata_i[16],
    wdata_i[17], wdata_i[18], wdata_i[19], wdata_i[20], wdata_i[24], wdata_i[25],
    wdata_i[28]} : '0;
  // The shadow count restarts on every fall, as the block's own must.
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      hold_r <= `RST_DATA_HOLD;
    else if (wr_i && addr_i == `OFS_DATA_HOLD)
      hold_r <= wdata_i[8:0];
    dcnt_r <= (sys_rst_i || req_i.scl_fall) ? 10'h1 : dcnt_r + 10'h1;
    darm_r <= !sys_rst_i && (req_i.scl_fall || (darm_r && !ack_o.data_change));
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_clear_update: assert property (
    pending_o == (($past(pending_o) & ~$past(clr)) | $past(event_i)))
    else $error("pending flags wrong after event or clear");
  a_reserved_zero: assert property (
    rd_i && addr_i == `OFS_DATA_HOLD |=> rdata_o[31:9] == 23'h0)
    else $error("reserved hold bits read nonzero");
  a_clear_reads_zero: assert property (
    rd_i && addr_i == `OFS_IRQ_CLEAR |=> rdata_o == 32'h0)
    else $error("clear register holds a value");
  a_hold_timing: assert property (
    (darm_r && dcnt_r == {1'b0, hold_r} + 10'h2) == ack_o.data_change)
    else $error("data change at wrong cycle");
  a_start_pulse: assert property (
    ack_o.scl_drive_low || ack_o.start_issue |=> ack_o[1:0] == 2'h0)
    else $error("start ack longer than one cycle");
  a_start_excl: assert property (
    !(ack_o.scl_drive_low && ack_o.start_issue))
    else $error("two start acks at once");
  a_mode_write: assert property (
    wr_i && addr_i == `OFS_MODE_CTRL |=> fast_mode_o == $past(wdata_i[0]))
    else $error("mode not taken from write");
  a_reset_clean: assert property (
    $fell(sys_rst_i) |-> pending_o == '0 && !fast_mode_o && rdata_o == 32'h0)
    else $error("outputs not clean after reset");
endmodule : i2c_irq_timing_sva

bind i2c_irq_timing i2c_irq_timing_sva chk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .event_i(event_i), .pending_o(pending_o), .req_i(req_i), .ack_o(ack_o),
  .fast_mode_o(fast_mode_o));

/* File: verification/tb.sv */
`timescale 1ns/1ps
`include "i2c_timing_map.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb
  import i2c_timing_pkg::*;
;
  localparam int POS [9] = '{3, 16, 17, 18, 19, 20, 24, 25, 28};
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  addr_i    = 8'h00;
  logic [31:0] wdata_i   = 32'h0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [31:0] rdata_o;
  irq_vec_t    ev_cmd    = '0;
  irq_vec_t    event_i;
  irq_vec_t    pending_o;
  timing_req_t rq_cmd    = '0;
  timing_req_t req_i;
  timing_ack_t ack_o;
  logic        fast_mode_o;
  int          checks      = 0;
  int          miscompares = 0;
  // A 4 ns period gives the 250 MHz clock.
  initial forever #2 ref_clk_i = ~ref_clk_i;
  i2c_irq_timing dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_i(event_i),
    .pending_o(pending_o), .req_i(req_i), .ack_o(ack_o), .fast_mode_o(fast_mode_o));
  engine_model engine (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ev_cmd_i(ev_cmd),
    .rq_cmd_i(rq_cmd), .event_o(event_i), .req_o(req_i));
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just there.
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(rdata_o, e)
  endtask : rd_chk
  // Counts cycles from the edge that takes the request to the ack.
  task meas(input timing_req_t r, input timing_ack_t m, output int n);
    rq_cmd <= r;
    @(posedge ref_clk_i);
    rq_cmd <= '0;
    n = 0;
    repeat (1200)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
      if ((ack_o & m) === m)
        break;
    end
  endtask : meas
  task t_reset_vals;
    int n;
    rd_chk(`OFS_DATA_HOLD, 32'h0000_0014);
    rd_chk(`OFS_START_HOLD, 32'h003F_00E2);
    rd_chk(`OFS_START_SETUP, 32'h001D_00E2);
    rd_chk(8'h10, 32'h0);
    `CHK(fast_mode_o, 1'b0)
    meas(3'h4, 3'h4, n);
    `CHK(n, 22)
  endtask : t_reset_vals
  // A zero write must leave all flags, then one bit clears only its own flag.
  task t_clear;
    for (int i = 0; i < 9; i++)
    begin
      ev_cmd <= '1;
      @(posedge ref_clk_i);
      ev_cmd <= '0;
      wr(`OFS_IRQ_CLEAR, 32'h0);
      rd_chk(`OFS_PENDING, `IRQ_MASK);
      wr(`OFS_IRQ_CLEAR, 32'h1 << POS[i]);
      rd_chk(`OFS_PENDING, `IRQ_MASK & ~(32'h1 << POS[i]));
      `CHK(pending_o, 9'h1FF & ~(9'h100 >> i))
    end
    // An event in the clear cycle must win over the clear, so no event is lost.
    ev_cmd <= '1;
    wr(`OFS_IRQ_CLEAR, `IRQ_MASK);
    ev_cmd <= '0;
    #1;
    `CHK(pending_o, 9'h1FF)
    wr(`OFS_IRQ_CLEAR, `IRQ_MASK);
    #1;
    `CHK(pending_o, 9'h000)
    rd_chk(`OFS_IRQ_CLEAR, 32'h0);
  endtask : t_clear
  task t_hold;
    int n;
    wr(`OFS_DATA_HOLD, 32'h0000_0005);
    rd_chk(`OFS_DATA_HOLD, 32'h0000_0005);
    meas(3'h4, 3'h4, n);
    `CHK(n, 7)
  endtask : t_hold
  task t_start(input logic f, input logic [7:0] a, input logic [31:0] v,
               input timing_req_t r, input timing_ack_t m);
    int n;
    wr(`OFS_MODE_CTRL, {31'h0, f});
    wr(a, v);
    rd_chk(a, v);
    `CHK(fast_mode_o, f)
    meas(r, m, n);
    `CHK(n, (f ? v[24:16] : v[8:0]) + 2)
  endtask : t_start
  task complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  // The run needs about 200 cycles; the watchdog allows 25000.
  initial
  begin
    #100000;
    miscompares++;
    complete_run;
  end
  initial
  begin
    repeat (4) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_reset_vals;
    t_clear;
    t_hold;
    t_start(1'b0, `OFS_START_HOLD, 32'h0009_0004, 3'h2, 3'h2);
    t_start(1'b1, `OFS_START_HOLD, 32'h0009_0004, 3'h2, 3'h2);
    t_start(1'b0, `OFS_START_SETUP, 32'h000B_0006, 3'h1, 3'h1);
    t_start(1'b1, `OFS_START_SETUP, 32'h000B_0006, 3'h1, 3'h1);
    complete_run;
  end
endmodule : tb
